/* core/aurx_pkg.sv */
// aurx_pkg: constants for the asynchronous serial receiver
// assumes one system clock and a plain register port on the receiver
package aurx_pkg;
   // register addresses of the plain port
   localparam logic [1:0] ADDR_STATUS = 2'h0;  // status_control_a
   localparam logic [1:0] ADDR_CTRL_B = 2'h1;  // control_b
   localparam logic [1:0] ADDR_FRAME_C = 2'h2; // frame_control_c
   localparam logic [1:0] ADDR_DATA = 2'h3;    // data_io_location
   // status_control_a bit positions
   localparam int ST_PARITY_ERR = 2;
   localparam int ST_OVERRUN = 3;
   localparam int ST_FRAMING_ERR = 4;
   localparam int ST_DOUBLE_SPEED = 1;
   localparam int ST_RX_COMPLETE = 7;
   // control_b bit positions
   localparam int CB_NINTH_RX = 1;
   localparam int CB_SIZE2 = 2;
   localparam int CB_RX_ENABLE = 4;
   localparam int CB_IRQ_ENABLE = 7;
   // frame_control_c bit positions
   localparam int FC_SIZE0 = 1;
   localparam int FC_SIZE1 = 2;
   localparam int FC_STOP_BITS = 3;
   localparam int FC_PARITY_ODD = 4;
   localparam int FC_PARITY_EN = 5;
   // reset values
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_FRAME_C = 8'h06;
   localparam logic [15:0] RST_BAUD_DIV = 16'h0000;
   // oversampling figures
   localparam logic [3:0] SAMPLES_NORMAL = 4'hF;  // last sample index, 16 per bit
   localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;  // last sample index, 8 per bit
   localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h7; // sample 8 counted from 1
   localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h3; // sample 4 counted from 1
   localparam int BUF_DEPTH = 2;
   typedef enum logic [1:0] {AURX_IDLE, AURX_START, AURX_BITS} aurx_state_t;
endpackage

/* core/aurx_receiver.sv */
// aurx_receiver: receive half of an asynchronous serial port
// assumes a sample tick divider value supplied by software; serial input is asynchronous
//
// The plain strobed port and the address map were left to the implementer.
module aurx_receiver
   import aurx_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DIV_W-1:0] baud_div,
   input wire logic global_irq_enable,
   input wire logic rx_pin,
   output logic [7:0] reg_rdata,
   output logic rx_irq,
   output logic pin_override
);
   import aurx_pkg::*;

   // majority of three samples
   function automatic logic vote3(input logic [2:0] s);
      vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   logic [7:0] control_b;
   logic [7:0] frame_control_c;
   logic double_speed_select;
   logic sync_a;
   logic sync_b;
   logic [DIV_W-1:0] div_cnt;
   logic tick;
   aurx_state_t state;
   logic [3:0] samp;
   logic [3:0] bit_idx;
   logic [2:0] votes;
   logic [8:0] shift;
   logic par_acc;
   logic frame_done;
   logic [8:0] done_data;
   logic done_fe;
   logic done_pe;
   logic shift_full;
   logic [8:0] sh_data;
   logic sh_fe;
   logic sh_pe;
   logic ovr_pending;
   logic start_seen;
   logic [11:0] buf_mem [BUF_DEPTH];
   logic rd_ptr;
   logic wr_ptr;
   logic [1:0] count;
   logic push;
   logic pop;
   logic receiver_enable;
   logic [3:0] last_samp;
   logic [3:0] vote_first;
   logic [3:0] nbits;
   logic [11:0] head;

   assign receiver_enable = control_b[CB_RX_ENABLE];
   // sample count per bit and start vote position
   assign last_samp = double_speed_select ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
   assign vote_first = double_speed_select ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
   // data bits 5..9 from size field, plus parity and one stop bit
   always_comb begin
      logic [2:0] sz;
      sz = {control_b[CB_SIZE2], frame_control_c[FC_SIZE1], frame_control_c[FC_SIZE0]};
      case (sz)
         3'h0: nbits = 4'h5;
         3'h1: nbits = 4'h6;
         3'h2: nbits = 4'h7;
         3'h7: nbits = 4'h9;
         default: nbits = 4'h8;
      endcase
   end
   assign head = buf_mem[rd_ptr];
   assign pop = reg_rd && reg_addr == ADDR_DATA && count != 2'h0;
   assign push = shift_full && (count != 2'(BUF_DEPTH) || pop);

   // input synchroniser
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end else begin
         sync_a <= rx_pin;
         sync_b <= sync_a;
      end
   end

   // oversampling tick from divider
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= '0;
         tick <= 1'b0;
      end else if (div_cnt == '0) begin
         div_cnt <= baud_div;
         tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt - 1'b1;
         tick <= 1'b0;
      end
   end

   // clock and data recovery state machine
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= AURX_IDLE;
         samp <= 4'h0;
         bit_idx <= 4'h0;
         votes <= 3'h0;
         shift <= 9'h000;
         par_acc <= 1'b0;
         frame_done <= 1'b0;
         done_data <= 9'h000;
         done_fe <= 1'b0;
         done_pe <= 1'b0;
         start_seen <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         start_seen <= 1'b0;
         if (!receiver_enable) begin
            state <= AURX_IDLE; // frame in progress dropped
         end else if (tick) begin
            case (state)
               AURX_IDLE: begin
                  if (!sync_b) begin // first low sample is sample 1
                     state <= AURX_START;
                     samp <= 4'h1;
                  end
               end
               AURX_START: begin
                  samp <= samp + 4'h1;
                  if (samp >= vote_first && samp <= vote_first + 4'h2)
                     votes <= {votes[1:0], sync_b};
                  if (samp == vote_first + 4'h2) begin
                     if (vote3({votes[1:0], sync_b})) begin
                        state <= AURX_IDLE; // noise spike
                     end else begin
                        state <= AURX_BITS;
                        start_seen <= 1'b1;
                        bit_idx <= 4'h0;
                        par_acc <= 1'b0;
                        shift <= 9'h000;
                     end
                  end
                  if (samp == last_samp) samp <= 4'h0;
               end
               AURX_BITS: begin
                  samp <= (samp == last_samp) ? 4'h0 : samp + 4'h1;
                  if (samp >= vote_first && samp <= vote_first + 4'h2)
                     votes <= {votes[1:0], sync_b};
                  if (samp == vote_first + 4'h2) begin
                     // three centre samples decide the bit
                     if (bit_idx < nbits) begin
                        shift[bit_idx] <= vote3({votes[1:0], sync_b});
                        par_acc <= par_acc ^ vote3({votes[1:0], sync_b});
                        bit_idx <= bit_idx + 4'h1;
                     end else if (bit_idx == nbits && frame_control_c[FC_PARITY_EN]) begin
                        // parity result stored only when enabled
                        done_pe <= (par_acc ^ vote3({votes[1:0], sync_b})) !=
                           frame_control_c[FC_PARITY_ODD];
                        bit_idx <= bit_idx + 4'h1;
                     end else begin
                        // first stop bit ends the frame
                        if (!frame_control_c[FC_PARITY_EN]) done_pe <= 1'b0;
                        done_fe <= !vote3({votes[1:0], sync_b});
                        done_data <= shift;
                        frame_done <= 1'b1;
                        state <= AURX_IDLE;
                     end
                  end
               end
               default: state <= AURX_IDLE;
            endcase
         end
      end
   end

   // shift register holding slot and overrun detection
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         shift_full <= 1'b0;
         sh_data <= 9'h000;
         sh_fe <= 1'b0;
         sh_pe <= 1'b0;
         ovr_pending <= 1'b0;
      end else if (!receiver_enable) begin
         shift_full <= 1'b0;
         ovr_pending <= 1'b0;
      end else begin
         if (start_seen && shift_full && count == 2'(BUF_DEPTH) && !pop)
            ovr_pending <= 1'b1;
         else if (push)
            ovr_pending <= 1'b0;
         // a new frame replaces a character that could not move on
         if (frame_done) begin
            shift_full <= 1'b1;
            sh_data <= done_data;
            sh_fe <= done_fe;
            sh_pe <= done_pe;
         end else if (push) begin
            shift_full <= 1'b0;
         end
      end
   end

   // two-entry receive buffer with per-character flags
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count <= 2'h0;
         for (int i = 0; i < BUF_DEPTH; i++) buf_mem[i] <= 12'h000;
      end else if (!receiver_enable) begin
         rd_ptr <= 1'b0; // flush
         wr_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            buf_mem[wr_ptr] <= {sh_fe, ovr_pending | (start_seen && count == 2'(BUF_DEPTH)),
               sh_pe, sh_data};
            wr_ptr <= ~wr_ptr;
         end
         if (pop) rd_ptr <= ~rd_ptr;
         count <= count + 2'(push) - 2'(pop);
      end
   end

   // control registers; error positions never written
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         control_b <= RST_CTRL_B;
         frame_control_c <= RST_FRAME_C;
         double_speed_select <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_STATUS: double_speed_select <= reg_wdata[ST_DOUBLE_SPEED];
            ADDR_CTRL_B: control_b <= reg_wdata & ~(8'h01 << CB_NINTH_RX);
            ADDR_FRAME_C: frame_control_c <= reg_wdata;
            default: ;
         endcase
      end
   end

   // read port, data one cycle after strobe
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_STATUS: reg_rdata <= {count != 2'h0, 2'h0, head[11] & (count != 2'h0),
               head[10] & (count != 2'h0),
               head[9] & (count != 2'h0) & frame_control_c[FC_PARITY_EN],
               double_speed_select, 1'b0};
            ADDR_CTRL_B: reg_rdata <= {control_b[7:2], head[8], control_b[0]};
            ADDR_FRAME_C: reg_rdata <= frame_control_c;
            // upper unused data bits masked
            ADDR_DATA: reg_rdata <= head[7:0] & ~(8'hFF << nbits[2:0] + 8'h0) |
               (nbits >= 4'h8 ? head[7:0] : 8'h00);
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // interrupt only from complete flag, not errors
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_irq <= 1'b0;
         pin_override <= 1'b0;
      end else begin
         rx_irq <= control_b[CB_IRQ_ENABLE] && global_irq_enable && count != 2'h0 &&
            receiver_enable && !pop;
         pin_override <= receiver_enable;
      end
   end
endmodule

/* tb/aurx_rx_asserts.sv */
// aurx_rx_asserts: port-level checks for the serial receiver
// assumes it is bound onto aurx_receiver; one clock, async active-low reset
module aurx_rx_asserts
   import aurx_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DIV_W-1:0] baud_div,
   input wire logic global_irq_enable,
   input wire logic rx_pin,
   input wire logic [7:0] reg_rdata,
   input wire logic rx_irq,
   input wire logic pin_override
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // control_b write seen on the port
   logic ctrl_wr;
   assign ctrl_wr = reg_wr && (reg_addr == ADDR_CTRL_B);
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   irq_gie_a: assert property ((!global_irq_enable) [*2] |-> !rx_irq)
      else $error("interrupt raised while globally masked");
   irq_rise_a: assert property ($rose(rx_irq) |-> $past(global_irq_enable))
      else $error("interrupt rose without global enable");
   irq_source_a: assert property (rx_irq |-> $past(pin_override, 2))
      else $error("interrupt with receiver disabled");
   irq_mask_a: assert property (ctrl_wr && !reg_wdata[CB_IRQ_ENABLE] |-> ##2 !rx_irq)
      else $error("interrupt stays after its enable cleared");
   override_follow_a: assert property (ctrl_wr |->
      ##2 pin_override == $past(reg_wdata[CB_RX_ENABLE], 2))
      else $error("pin ownership does not follow receiver enable");
   override_hold_a: assert property (!ctrl_wr ##1 !ctrl_wr |=> $stable(pin_override))
      else $error("pin ownership changed without a control write");
   flush_status_a: assert property ((!pin_override) [*2] ##0
      (reg_rd && reg_addr == ADDR_STATUS) |=> reg_rdata[ST_RX_COMPLETE] == 1'b0)
      else $error("complete flag set while receiver disabled");
endmodule

bind aurx_receiver aurx_rx_asserts #(.DIV_W(DIV_W)) chk_u (.ref_clk(ref_clk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .baud_div(baud_div), .global_irq_enable(global_irq_enable), .rx_pin(rx_pin),
   .reg_rdata(reg_rdata), .rx_irq(rx_irq), .pin_override(pin_override));

/* tb/aurx_line_model.sv */
// aurx_line_model: remote transmitter driving the serial receive line
// assumes the bench calls its tasks; the line idles high as if pulled up
module aurx_line_model (
   input wire logic ref_clk,
   output logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial line = 1'b1;
   // start bit, then n frame bits lsb first, each bclk clocks long
   task automatic send(input logic [10:0] bits, input int n, input int bclk);
      line <= 1'b0;
      repeat (bclk) @(posedge ref_clk);
      for (int i = 0; i < n; i++) begin
         line <= bits[i];
         repeat (bclk) @(posedge ref_clk);
      end
      line <= 1'b1;
   endtask
   // low glitch ending before the start vote
   task automatic spike(input int clks);
      line <= 1'b0;
      repeat (clks) @(posedge ref_clk);
      line <= 1'b1;
   endtask
endmodule

/* tb/testbench.sv */
// testbench: directed scenarios for the serial receiver
// assumes baud_div 1, so 32 clocks a bit normal and 16 double speed
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import aurx_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic gie = 1'b0;
   logic [15:0] baud_div = 16'h0001;
   logic rx_line;
   logic [7:0] reg_rdata;
   logic rx_irq;
   logic pin_override;
   logic [7:0] v;
   int err_total = 0;
   int checks_done = 0;
   aurx_receiver #(.DIV_W(16)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .baud_div(baud_div),
      .global_irq_enable(gie), .rx_pin(rx_line), .reg_rdata(reg_rdata), .rx_irq(rx_irq),
      .pin_override(pin_override));
   aurx_line_model line_u (.ref_clk(ref_clk), .line(rx_line));
   always #2 ref_clk = ~ref_clk;
   // compare and count
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // one-cycle read, data taken in the answer cycle
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // status then data of the next buffered character
   task automatic expect_rx(input logic [7:0] st, input logic [7:0] dat);
      rd(ADDR_STATUS, v);
      check8(v & 8'h9C, st);
      rd(ADDR_DATA, v);
      check8(v, dat);
   endtask
   // one 8-bit character, flag, interrupt and masking
   task automatic sc_basic();
      gie <= 1'b1;
      wr(ADDR_CTRL_B, 8'h90);
      wr(ADDR_FRAME_C, 8'h06);
      line_u.send({2'b11, 1'b1, 8'hA5}, 9, 32);
      repeat (4) @(posedge ref_clk);
      check8({7'h00, rx_irq}, 8'h01);
      gie <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check8({7'h00, rx_irq}, 8'h00);
      gie <= 1'b1;
      wr(ADDR_CTRL_B, 8'h10);
      repeat (3) @(posedge ref_clk);
      check8({7'h00, rx_irq}, 8'h00);
      wr(ADDR_CTRL_B, 8'h90);
      expect_rx(8'h80, 8'hA5);
      repeat (3) @(posedge ref_clk);
      check8({7'h00, rx_irq}, 8'h00);
   endtask
   // bad parity with bad stop, then good odd parity, flags follow each char
   task automatic sc_errors();
      wr(ADDR_FRAME_C, 8'h26);
      line_u.send({2'b00, 1'b0, 1'b1, 8'h3C}, 10, 32);
      wr(ADDR_FRAME_C, 8'h36);
      line_u.send({2'b00, 1'b1, 1'b1, 8'h3C}, 10, 32);
      expect_rx(8'h94, 8'h3C);
      expect_rx(8'h80, 8'h3C);
   endtask
   // four chars unread: third lost, fourth flagged, then flag clears
   task automatic sc_overrun();
      wr(ADDR_FRAME_C, 8'h06);
      line_u.send({3'b001, 8'h11}, 9, 32);
      line_u.send({3'b001, 8'h22}, 9, 32);
      line_u.send({3'b001, 8'h33}, 9, 32);
      line_u.send({3'b001, 8'h44}, 9, 32);
      expect_rx(8'h80, 8'h11);
      expect_rx(8'h80, 8'h22);
      expect_rx(8'h88, 8'h44);
      line_u.send({3'b001, 8'h55}, 9, 32);
      expect_rx(8'h80, 8'h55);
   endtask
   // nine data bits, ninth bit read from control_b before data
   task automatic sc_ninth();
      wr(ADDR_CTRL_B, 8'h94);
      line_u.send({1'b0, 1'b1, 1'b1, 8'h5A}, 10, 32);
      rd(ADDR_CTRL_B, v);
      check8(v, 8'h96);
      expect_rx(8'h80, 8'h5A);
      wr(ADDR_CTRL_B, 8'h90);
   endtask
   // double speed 7-bit char, then disable flushes a pending char
   task automatic sc_double_disable();
      wr(ADDR_STATUS, 8'h02);
      wr(ADDR_FRAME_C, 8'h04);
      line_u.send({3'b000, 1'b1, 7'h7F}, 8, 16);
      expect_rx(8'h80, 8'h7F);
      line_u.send({3'b000, 1'b1, 7'h2A}, 8, 16);
      wr(ADDR_CTRL_B, 8'h80);
      repeat (3) @(posedge ref_clk);
      rd(ADDR_STATUS, v);
      check8(v & 8'h9C, 8'h00);
      check8({6'h00, rx_irq, pin_override}, 8'h00);
      wr(ADDR_STATUS, 8'h00);
      wr(ADDR_CTRL_B, 8'h90);
   endtask
   // a glitch shorter than the vote point is no start bit
   task automatic sc_spike();
      line_u.spike(4);
      repeat (400) @(posedge ref_clk);
      rd(ADDR_STATUS, v);
      check8(v & 8'h9C, 8'h00);
   endtask
   // verdict and end of run
   task automatic close_out();
      $display("mismatches=%0d comparisons=%0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // watchdog well past the expected run
   initial begin
      repeat (20000) @(posedge ref_clk);
      check8(8'h00, 8'h01);
      close_out();
   end
   // main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      sc_basic();
      sc_errors();
      sc_overrun();
      sc_ninth();
      sc_double_disable();
      sc_spike();
      close_out();
   end
endmodule
